// ===== hdl/cmh_pkg.sv
// Package with constants and types for the logic array macrocell host access.
package cmh_pkg;

	// ***************************************************************
	// Sizes
	// ***************************************************************
	localparam int CELLS = 16;
	localparam int GROUP = 8;
	localparam int INPUTS = 24;
	localparam int NIBBLES = 6;

	// ***************************************************************
	// Register offsets in the configuration register space
	// ***************************************************************
	localparam logic [7:0] OFS_IN_A = 8'h00;
	localparam logic [7:0] OFS_IN_B = 8'h01;
	localparam logic [7:0] OFS_IN_C = 8'h02;
	localparam logic [7:0] OFS_DOUT_A = 8'h04;
	localparam logic [7:0] OFS_DOUT_B = 8'h05;
	localparam logic [7:0] OFS_DOUT_C = 8'h06;
	localparam logic [7:0] OFS_DIR_A = 8'h08;
	localparam logic [7:0] OFS_DIR_B = 8'h09;
	localparam logic [7:0] OFS_DIR_C = 8'h0a;
	localparam logic [7:0] OFS_OUT_AB = 8'h20;
	localparam logic [7:0] OFS_OUT_BC = 8'h21;
	localparam logic [7:0] OFS_MASK_AB = 8'h22;
	localparam logic [7:0] OFS_MASK_BC = 8'h23;
	localparam logic [7:0] OFS_UNMAPPED_RD = 8'h00;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] DOUT_RST = 8'h00;
	localparam logic [15:0] CELL_RST = 16'h0000;

	// ***************************************************************
	// Product term budgets
	// ***************************************************************
	localparam logic [3:0] NATIVE_AB = 4'h3;
	localparam logic [3:0] NATIVE_BC = 4'h4;
	localparam logic [3:0] BORROW_AB = 4'h6;
	localparam logic [3:0] BORROW_BC_LO = 4'h5;
	localparam logic [3:0] BORROW_BC_HI = 4'h6;

	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [1:0] {
		IN_PASS = 2'b00,
		IN_LATCH = 2'b01,
		IN_REG = 2'b11
	} cmh_in_mode_t;

	typedef struct packed {
		logic ale;
		logic wr;
		logic rd;
		logic sel;
		logic ext_clk;
		logic control_input_2;
	} cmh_host_t;

	typedef struct packed {
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} cmh_ports_t;

endpackage : cmh_pkg

// ===== hdl/cmh_macrocell_host.sv
// Output and input macrocells of the logic array with host load and readback.
// What this block does
// - First group owns three, borrows six terms
// - Used terms unavailable; borrow only from next two cells
// - Excess terms consume cells and add delay
// - All sixteen cell flops loadable from host
// - Host load beats preset, clear and clock
// - Host reads back cell flop states
// - Edge or level loading by configuration
// - One mask per group, resets to zero
// - Mask bit one blocks that cell's load
// - Pin enable is term OR direction bit
// - Array output without enable term drives always
// - Internal node frees pin, still feeds back
// - Twenty-four input cells: latch, register, pass
// - Input clock from term or address strobe
// - One term clocks each nibble of inputs
// - Input cells feed array and host reads
// - Strobe-clocked input cells capture port pins
// - Mailbox through data out and input cells
// - Address latched on strobe, optionally shown
// - Shared port driven only on selected read
// - Extra address bits accepted on ports
// - Unused third control feeds the array
// - External clock rising edge; set, clear high
// - Cell n pairs with data bit n mod 8
`timescale 1ns/1ns
`default_nettype none
module cmh_macrocell_host (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] shared_addr_data_port_i,
	output logic [7:0] shared_addr_data_port_o,
	output logic shared_addr_data_port_oe_o,
	input wire logic [7:0] addr_hi_i,
	input wire logic address_latch_strobe_i,
	input wire logic control_input_0_n_i,
	input wire logic control_input_1_n_i,
	input wire logic control_input_2_i,
	input wire logic config_space_sel_i,
	input wire logic external_clock_input_i,
	input wire cmh_pkg::cmh_ports_t port_i,
	output cmh_pkg::cmh_ports_t port_o,
	output cmh_pkg::cmh_ports_t port_oe_o,
	input wire logic [15:0] pt_d_i,
	input wire logic [15:0] pt_clk_i,
	input wire logic [15:0] pt_pre_i,
	input wire logic [15:0] pt_clr_i,
	input wire logic [23:0] pt_oe_i,
	input wire logic [5:0] pt_in_clk_i,
	input wire logic cfg_level_load_i,
	input wire logic [15:0] cfg_ext_clk_i,
	input wire logic [15:0] cfg_cell_is_pin_i,
	input wire logic [15:0] cfg_oe_eq_i,
	input wire cmh_pkg::cmh_in_mode_t [23:0] cfg_in_mode_i,
	input wire logic [5:0] cfg_in_ale_sel_i,
	input wire logic cfg_addr_out_i,
	input wire logic cfg_control_input_2_free_i,
	input wire logic [15:0][3:0] cfg_pterm_req_i,
	output logic [15:0] cell_fb_o,
	output logic [23:0] imc_o,
	output logic [15:0] array_addr_o,
	output logic array_control_input_2_o,
	output logic [15:0] expanded_o,
	output logic [15:0] consumed_o
);
	import cmh_pkg::*;

	// ***************************************************************
	// Helper functions
	// ***************************************************************
	function automatic logic [3:0] native_terms(input int c);
		native_terms = (c < GROUP) ? NATIVE_AB : NATIVE_BC;
	endfunction : native_terms

	function automatic logic [3:0] max_borrow(input int c);
		if (c < GROUP)
			max_borrow = BORROW_AB;
		else if (c < GROUP + 4)
			max_borrow = BORROW_BC_LO;
		else
			max_borrow = BORROW_BC_HI;
	endfunction : max_borrow

	function automatic logic [3:0] min4(input logic [3:0] x,
		input logic [3:0] y);
		min4 = (x < y) ? x : y;
	endfunction : min4

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	cmh_host_t host_s1;
	cmh_host_t host_s2;
	cmh_host_t host_d;
	logic [7:0] shared_addr_data_port_s1;
	logic [7:0] shared_addr_data_port_s2;
	logic [7:0] hi_s1;
	logic [7:0] hi_s2;
	cmh_ports_t port_s1;
	cmh_ports_t port_s2;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_s1 <= '0;
			host_s2 <= '0;
			host_d <= '0;
			shared_addr_data_port_s1 <= 8'h00;
			shared_addr_data_port_s2 <= 8'h00;
			hi_s1 <= 8'h00;
			hi_s2 <= 8'h00;
			port_s1 <= '0;
			port_s2 <= '0;
		end else begin
			host_s1 <= '{ale: address_latch_strobe_i,
				wr: !control_input_0_n_i, rd: !control_input_1_n_i,
				sel: config_space_sel_i, ext_clk: external_clock_input_i,
				control_input_2: control_input_2_i};
			host_s2 <= host_s1;
			host_d <= host_s2;
			shared_addr_data_port_s1 <= shared_addr_data_port_i;
			shared_addr_data_port_s2 <= shared_addr_data_port_s1;
			hi_s1 <= addr_hi_i;
			hi_s2 <= hi_s1;
			port_s1 <= port_i;
			port_s2 <= port_s1;
		end
	end

	logic wr_release;
	logic ext_rise;
	logic ale_rise;
	assign wr_release = host_d.wr && !host_s2.wr;
	assign ext_rise = host_s2.ext_clk && !host_d.ext_clk;
	assign ale_rise = host_s2.ale && !host_d.ale;

	// ***************************************************************
	// Address latch and write data capture
	// ***************************************************************
	// The low address byte shares the port with data, so it is held
	// from the strobe until the next one.
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] next_wdata;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			addr <= 16'h0000;
		else if (host_s2.ale)
			addr <= {hi_s2, shared_addr_data_port_s2};
	end

	// Data is sampled while the strobe is held, so the value used at the
	// release edge is one that was stable during the strobe.
	assign next_wdata = host_s2.wr ? shared_addr_data_port_s2 : wdata;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wdata <= 8'h00;
		else
			wdata <= next_wdata;
	end

	logic reg_wr;
	logic cell_load;
	assign reg_wr = wr_release && host_d.sel;
	assign cell_load = host_d.sel && (cfg_level_load_i ?
		host_s2.wr : wr_release);

	// ***************************************************************
	// Host registers
	// ***************************************************************
	logic [7:0] mask_ab;
	logic [7:0] mask_bc;
	cmh_ports_t dout;
	cmh_ports_t dir;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_ab <= MASK_RST;
			mask_bc <= MASK_RST;
		end else if (reg_wr && addr[7:0] == OFS_MASK_AB)
			mask_ab <= wdata;
		else if (reg_wr && addr[7:0] == OFS_MASK_BC)
			mask_bc <= wdata;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dout <= '{a: DOUT_RST, b: DOUT_RST, c: DOUT_RST};
			dir <= '{a: DIR_RST, b: DIR_RST, c: DIR_RST};
		end else if (reg_wr) begin
			case (addr[7:0])
				OFS_DOUT_A: dout.a <= wdata;
				OFS_DOUT_B: dout.b <= wdata;
				OFS_DOUT_C: dout.c <= wdata;
				OFS_DIR_A: dir.a <= wdata;
				OFS_DIR_B: dir.b <= wdata;
				OFS_DIR_C: dir.c <= wdata;
				default: dir <= dir;
			endcase
		end
	end

	// ***************************************************************
	// Output cell flip-flops
	// ***************************************************************
	logic [15:0] cell_q;
	logic [15:0] pt_clk_d;
	logic [15:0] load_sel;
	logic [15:0] next_cell_q;

	always_comb begin
		load_sel = 16'h0000;
		if (cell_load && addr[7:0] == OFS_OUT_AB)
			load_sel[7:0] = ~mask_ab;
		if (cell_load && addr[7:0] == OFS_OUT_BC)
			load_sel[15:8] = ~mask_bc;
	end

	always_comb begin
		for (int c = 0; c < CELLS; c++) begin
			if (load_sel[c])
				next_cell_q[c] = wdata[c % GROUP];
			else if (pt_clr_i[c])
				next_cell_q[c] = 1'b0;
			else if (pt_pre_i[c])
				next_cell_q[c] = 1'b1;
			else if (cfg_ext_clk_i[c] ? ext_rise :
				(pt_clk_i[c] && !pt_clk_d[c]))
				next_cell_q[c] = pt_d_i[c];
			else
				next_cell_q[c] = cell_q[c];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cell_q <= CELL_RST;
			pt_clk_d <= 16'h0000;
		end else begin
			cell_q <= next_cell_q;
			pt_clk_d <= pt_clk_i;
		end
	end

	// ***************************************************************
	// Product term allocation
	// ***************************************************************
	// Each cell may borrow only from its next two cells in its own group,
	// wrapping; one neighbour alone cannot supply the full borrow budget.
	// A term once granted is removed from that neighbour's spare.
	logic [15:0][3:0] spare;
	logic [15:0] next_expanded;
	logic [15:0] next_consumed;

	always_comb begin
		logic [3:0] need;
		logic [3:0] take;
		logic [3:0] left;
		logic [3:0] got;
		int nb;
		need = 4'h0;
		take = 4'h0;
		left = 4'h0;
		got = 4'h0;
		nb = 0;
		next_expanded = 16'h0000;
		next_consumed = 16'h0000;
		for (int c = 0; c < CELLS; c++)
			spare[c] = (cfg_pterm_req_i[c] < native_terms(c)) ?
				4'(native_terms(c) - cfg_pterm_req_i[c]) : 4'h0;
		for (int c = 0; c < CELLS; c++) begin
			need = (cfg_pterm_req_i[c] > native_terms(c)) ?
				4'(cfg_pterm_req_i[c] - native_terms(c)) : 4'h0;
			left = min4(need, max_borrow(c));
			got = 4'h0;
			for (int k = 1; k <= 2; k++) begin
				nb = c - (c % GROUP) + ((c % GROUP + k) % GROUP);
				take = min4(left, spare[nb]);
				spare[nb] = 4'(spare[nb] - take);
				left = 4'(left - take);
				got = 4'(got + take);
			end
			nb = c - (c % GROUP) + ((c % GROUP + 1) % GROUP);
			if (need > got) begin
				next_expanded[c] = 1'b1;
				next_consumed[nb] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			expanded_o <= 16'h0000;
			consumed_o <= 16'h0000;
		end else begin
			expanded_o <= next_expanded;
			consumed_o <= next_consumed;
		end
	end

	// An expanded equation passes one extra stage, as its extra terms are
	// formed in another cell first.
	logic [15:0] cell_late;
	logic [15:0] cell_out;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cell_late <= CELL_RST;
		else
			cell_late <= cell_q;
	end

	assign cell_out = (expanded_o & cell_late) | (~expanded_o & cell_q);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cell_fb_o <= CELL_RST;
		else
			cell_fb_o <= cell_out;
	end

	// ***************************************************************
	// Input cells
	// ***************************************************************
	logic [23:0] in_pins;
	logic [5:0] in_en;
	logic [5:0] in_en_d;
	logic [23:0] in_hold;
	logic [23:0] next_imc;

	assign in_pins = {port_s2.c, port_s2.b, port_s2.a};

	always_comb begin
		for (int n = 0; n < NIBBLES; n++)
			in_en[n] = cfg_in_ale_sel_i[n] ? host_s2.ale :
				pt_in_clk_i[n];
	end

	always_comb begin
		for (int i = 0; i < INPUTS; i++) begin
			case (cfg_in_mode_i[i])
				IN_PASS: next_imc[i] = in_pins[i];
				IN_LATCH: next_imc[i] = in_en[i / 4] ? in_pins[i] :
					in_hold[i];
				IN_REG: next_imc[i] = (in_en[i / 4] && !in_en_d[i / 4]) ?
					in_pins[i] : in_hold[i];
				default: next_imc[i] = in_pins[i];
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_hold <= 24'h000000;
			in_en_d <= 6'h00;
			imc_o <= 24'h000000;
		end else begin
			in_hold <= next_imc;
			in_en_d <= in_en;
			imc_o <= next_imc;
		end
	end

	// ***************************************************************
	// Array inputs from the host bus
	// ***************************************************************
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			array_addr_o <= 16'h0000;
			array_control_input_2_o <= 1'b0;
		end else begin
			array_addr_o <= addr;
			array_control_input_2_o <= cfg_control_input_2_free_i & host_s2.control_input_2;
		end
	end

	// ***************************************************************
	// Port pin drivers
	// ***************************************************************
	// First group drives port A, second group port C; port B carries
	// its data out register or the latched address.
	logic [15:0] drive_cell;
	cmh_ports_t next_port;
	cmh_ports_t next_oe;

	assign drive_cell = cfg_cell_is_pin_i;

	always_comb begin
		next_port.a = (drive_cell[7:0] & cell_out[7:0]) |
			(~drive_cell[7:0] & dout.a);
		next_port.c = (drive_cell[15:8] & cell_out[15:8]) |
			(~drive_cell[15:8] & dout.c);
		next_port.b = cfg_addr_out_i ? addr[7:0] : dout.b;
		next_oe = pt_oe_i | dir;
		next_oe.a = next_oe.a | (drive_cell[7:0] & ~cfg_oe_eq_i[7:0]);
		next_oe.c = next_oe.c | (drive_cell[15:8] & ~cfg_oe_eq_i[15:8]);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_o <= '0;
			port_oe_o <= '0;
		end else begin
			port_o <= next_port;
			port_oe_o <= next_oe;
		end
	end

	// ***************************************************************
	// Host readback on the shared port
	// ***************************************************************
	logic [7:0] next_rdata;

	always_comb begin
		case (addr[7:0])
			OFS_IN_A: next_rdata = imc_o[7:0];
			OFS_IN_B: next_rdata = imc_o[15:8];
			OFS_IN_C: next_rdata = imc_o[23:16];
			OFS_DOUT_A: next_rdata = dout.a;
			OFS_DOUT_B: next_rdata = dout.b;
			OFS_DOUT_C: next_rdata = dout.c;
			OFS_DIR_A: next_rdata = dir.a;
			OFS_DIR_B: next_rdata = dir.b;
			OFS_DIR_C: next_rdata = dir.c;
			OFS_OUT_AB: next_rdata = cell_q[7:0];
			OFS_OUT_BC: next_rdata = cell_q[15:8];
			OFS_MASK_AB: next_rdata = mask_ab;
			OFS_MASK_BC: next_rdata = mask_bc;
			default: next_rdata = OFS_UNMAPPED_RD;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shared_addr_data_port_o <= 8'h00;
			shared_addr_data_port_oe_o <= 1'b0;
		end else begin
			shared_addr_data_port_o <= next_rdata;
			shared_addr_data_port_oe_o <= host_s2.sel && host_s2.rd;
		end
	end

endmodule : cmh_macrocell_host
`default_nettype wire

// ===== tb/cmh_macrocell_host_checker.sv
// Concurrent checks on the ports of the macrocell host access block.
`timescale 1ns/1ns
`default_nettype none
module cmh_macrocell_host_checker (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] shared_addr_data_port_i,
	input wire logic shared_addr_data_port_oe_o,
	input wire logic [7:0] addr_hi_i,
	input wire logic address_latch_strobe_i,
	input wire logic control_input_0_n_i,
	input wire logic control_input_1_n_i,
	input wire logic control_input_2_i,
	input wire logic config_space_sel_i,
	input wire logic [15:0] pt_pre_i,
	input wire logic [15:0] pt_clr_i,
	input wire logic [23:0] pt_oe_i,
	input wire logic cfg_control_input_2_free_i,
	input wire logic [15:0][3:0] cfg_pterm_req_i,
	input wire cmh_pkg::cmh_ports_t port_oe_o,
	input wire logic [15:0] cell_fb_o,
	input wire logic [15:0] array_addr_o,
	input wire logic array_control_input_2_o,
	input wire logic [15:0] expanded_o
);
	import cmh_pkg::*;
	logic rd_sel;
	assign rd_sel = !control_input_1_n_i && config_space_sel_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	// ************
	// Sequences and properties
	// ************
	// Six quiet cycles cover the strobe synchroniser and the feedback flop.
	sequence s_quiet;
		(control_input_0_n_i && $stable(pt_clr_i) && $stable(pt_pre_i))[*6];
	endsequence
	sequence s_addr_held;
		(address_latch_strobe_i && $stable({addr_hi_i, shared_addr_data_port_i}))[*5];
	endsequence
	property p_alloc;
		$stable(cfg_pterm_req_i)[*3] |->
			expanded_o[0] == (cfg_pterm_req_i[0] > 4'h9) &&
			expanded_o[8] == (cfg_pterm_req_i[8] > 4'h9) &&
			expanded_o[12] == (cfg_pterm_req_i[12] > 4'ha);
	endproperty

	read_drive_a: assert property (rd_sel[*5] |-> shared_addr_data_port_oe_o)
		else $error("shared port not driven on selected read");
	drive_cause_a: assert property (shared_addr_data_port_oe_o |->
		$past(rd_sel, 2) || $past(rd_sel, 3) || $past(rd_sel, 4))
		else $error("shared port driven without selected read");
	oe_or_a: assert property ((pt_oe_i == $past(pt_oe_i)) |->
		(pt_oe_i & ~port_oe_o) == 24'h000000)
		else $error("pin enable term does not enable driver");
	ctl2_route_a: assert property
		((cfg_control_input_2_free_i && control_input_2_i)[*4] |-> array_control_input_2_o)
		else $error("third control input not routed to array");
	clear_wins_a: assert property
		(s_quiet |-> (pt_clr_i & cell_fb_o) == 16'h0000)
		else $error("active clear did not clear cell");
	preset_hold_a: assert property
		(s_quiet |-> (pt_pre_i & ~pt_clr_i & ~cell_fb_o) == 16'h0000)
		else $error("active preset did not set cell");
	addr_latch_a: assert property
		(s_addr_held |-> array_addr_o == {addr_hi_i, shared_addr_data_port_i})
		else $error("address not latched on strobe");
	alloc_limit_a: assert property (p_alloc)
		else $error("expansion flag disagrees with term budget");
endmodule : cmh_macrocell_host_checker

bind cmh_macrocell_host cmh_macrocell_host_checker u_checker (.*);
`default_nettype wire

// ===== tb/cmh_host_model.sv
// Host processor model driving strobes and the shared address/data pins.
`timescale 1ns/1ns
`default_nettype none
module cmh_host_model (
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] d_o,
	output logic en_o,
	output logic [7:0] hi_o,
	output logic ale_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic sel_o
);
	initial begin
		{d_o, hi_o, ale_o, sel_o} = '0;
		{en_o, wr_n_o, rd_n_o} = '1;
	end

	// ************
	// Bus cycles
	// ************
	task automatic addr_phase(input logic [15:0] a);
		@(posedge clk_i);
		ale_o <= 1'b1;
		hi_o <= a[15:8];
		d_o <= a[7:0];
		en_o <= 1'b1;
		repeat (6) @(posedge clk_i);
		ale_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : addr_phase

	task automatic write(input logic [15:0] a, input logic [7:0] d,
		input int hold);
		addr_phase(a);
		sel_o <= 1'b1;
		wr_n_o <= 1'b0;
		d_o <= d;
		repeat (hold) @(posedge clk_i);
		wr_n_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		sel_o <= 1'b0;
		// Stale data would hide a late capture, so the bus changes.
		d_o <= ~d;
		repeat (3) @(posedge clk_i);
	endtask : write

	task automatic read(input logic [15:0] a, input logic sel,
		output logic [7:0] d, output logic ok);
		addr_phase(a);
		en_o <= 1'b0;
		sel_o <= sel;
		rd_n_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 8 && !oe_i; i++) begin
			@(posedge clk_i);
		end
		repeat (2) @(posedge clk_i);
		ok = oe_i;
		d = rdata_i;
		rd_n_o <= 1'b1;
		sel_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		en_o <= 1'b1;
	endtask : read
endmodule : cmh_host_model
`default_nettype wire

// ===== tb/cmh_macrocell_host_tb_top.sv
// Testbench for the macrocell host access block.
`timescale 1ns/1ns
`default_nettype none
module cmh_macrocell_host_tb_top;
	import cmh_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] shared_addr_data_port_i, shared_addr_data_port_o, addr_hi_i, h_d, rd_v;
	logic shared_addr_data_port_oe_o, address_latch_strobe_i, control_input_0_n_i;
	logic control_input_1_n_i, control_input_2_i, config_space_sel_i;
	logic external_clock_input_i, cfg_level_load_i, cfg_addr_out_i;
	logic cfg_control_input_2_free_i, array_control_input_2_o, h_en, rd_ok;
	cmh_ports_t port_i, port_o, port_oe_o;
	logic [15:0] pt_d_i, pt_clk_i, pt_pre_i, pt_clr_i, cfg_ext_clk_i;
	logic [15:0] cfg_cell_is_pin_i, cfg_oe_eq_i, cell_fb_o, array_addr_o;
	logic [15:0] expanded_o, consumed_o;
	logic [23:0] pt_oe_i, imc_o;
	logic [5:0] pt_in_clk_i, cfg_in_ale_sel_i;
	cmh_in_mode_t [23:0] cfg_in_mode_i;
	logic [15:0][3:0] cfg_pterm_req_i;
	int cel[3] = '{0, 8, 12};
	logic [3:0] lim[3] = '{4'h9, 4'h9, 4'ha};
	int miscompares = 0;
	int compares = 0;

	always #4 ref_clk_i = ~ref_clk_i;
	// Undriven bus shows the inverse of the last value, never a held copy.
	assign shared_addr_data_port_i = shared_addr_data_port_oe_o ? shared_addr_data_port_o : (h_en ? h_d : ~h_d);

	cmh_host_model host (.clk_i(ref_clk_i), .oe_i(shared_addr_data_port_oe_o),
		.rdata_i(shared_addr_data_port_o), .d_o(h_d), .en_o(h_en), .hi_o(addr_hi_i),
		.ale_o(address_latch_strobe_i), .wr_n_o(control_input_0_n_i),
		.rd_n_o(control_input_1_n_i), .sel_o(config_space_sel_i));
	cmh_macrocell_host dut (.*);

	// ************
	// Helpers
	// ************
	task automatic check(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : cyc

	task automatic wr(input logic [7:0] o, d);
		host.write({8'h5a, o}, d, 5);
	endtask : wr

	task automatic rd(input logic [7:0] o, exp, input string what);
		host.read({8'h5a, o}, 1'b1, rd_v, rd_ok);
		check(what, rd_v, exp);
	endtask : rd

	// Samples mid-strobe, where level and edge loading differ.
	task automatic probe(input logic lv, input logic [7:0] d, mid);
		cfg_level_load_i <= lv;
		fork
			host.write({8'h5a, OFS_OUT_AB}, d, 10);
			begin
				cyc(16);
				check("mid_load", cell_fb_o[7:0], mid);
			end
		join
	endtask : probe

	initial begin
		#400000;
		miscompares++;
		end_sim();
	end

	initial begin
		{port_i, pt_d_i, pt_clk_i, pt_pre_i, pt_clr_i, pt_oe_i} = '0;
		{pt_in_clk_i, cfg_level_load_i, cfg_ext_clk_i, cfg_addr_out_i} = '0;
		{cfg_cell_is_pin_i, cfg_in_ale_sel_i, cfg_control_input_2_free_i} = '0;
		{cfg_pterm_req_i, control_input_2_i, external_clock_input_i} = '0;
		cfg_oe_eq_i = '1;
		cfg_in_mode_i = {24{IN_PASS}};
		cyc(20);
		rst_n_i <= 1'b1;
		rd(OFS_MASK_AB, MASK_RST, "mask_ab");
		rd(OFS_MASK_BC, MASK_RST, "mask_bc");
		wr(OFS_OUT_AB, 8'ha5);
		check("addr", array_addr_o, {8'h5a, OFS_OUT_AB});
		wr(OFS_OUT_BC, 8'h3c);
		rd(OFS_OUT_AB, 8'ha5, "out_ab");
		rd(OFS_OUT_BC, 8'h3c, "out_bc");
		check("fb", cell_fb_o, 16'h3ca5);
		wr(8'h30, 8'hff);
		rd(8'h30, OFS_UNMAPPED_RD, "unmapped");
		wr(OFS_MASK_AB, 8'h0f);
		rd(OFS_MASK_AB, 8'h0f, "mask_ab");
		wr(OFS_OUT_AB, 8'h5a);
		rd(OFS_OUT_AB, 8'h55, "masked_ab");
		wr(OFS_MASK_BC, 8'hff);
		wr(OFS_OUT_BC, 8'h00);
		rd(OFS_OUT_BC, 8'h3c, "masked_bc");
		wr(OFS_MASK_AB, MASK_RST);
		wr(OFS_MASK_BC, MASK_RST);
		pt_pre_i <= 16'h00ff;
		probe(1'b1, 8'h96, 8'h96);
		cyc(8);
		check("preset", cell_fb_o[7:0], 8'hff);
		pt_pre_i <= '0;
		probe(1'b0, 8'h69, 8'hff);
		rd(OFS_OUT_AB, 8'h69, "edge");
		pt_clr_i <= 16'hff00;
		cyc(8);
		check("clear", cell_fb_o[15:8], 8'h00);
		pt_clr_i <= '0;
		pt_d_i <= 16'h0300;
		cfg_ext_clk_i <= 16'h0100;
		cyc(2);
		external_clock_input_i <= 1'b1;
		cyc(6);
		check("ext_clk", cell_fb_o[9:8], 2'b01);
		wr(OFS_DIR_A, 8'h0f);
		check("oe_dir", port_oe_o.a, 8'h0f);
		pt_oe_i <= 24'h0000f0;
		cyc(3);
		check("oe_or", port_oe_o.a, 8'hff);
		pt_oe_i <= '0;
		cfg_cell_is_pin_i <= 16'h00ff;
		cfg_oe_eq_i <= 16'hff00;
		cyc(3);
		check("oe_pin", port_oe_o.a, 8'hff);
		port_i.a <= 8'h3c;
		cyc(5);
		check("pass", imc_o[7:0], 8'h3c);
		rd(OFS_IN_A, 8'h3c, "in_a");
		cfg_in_mode_i[7:0] <= {8{IN_LATCH}};
		pt_in_clk_i[1:0] <= 2'b11;
		cyc(5);
		pt_in_clk_i[1:0] <= 2'b00;
		port_i.a <= 8'hc3;
		cyc(5);
		pt_in_clk_i[0] <= 1'b1;
		cyc(5);
		check("latch", imc_o[7:0], 8'h33);
		rd(OFS_IN_A, 8'h33, "mailbox");
		cfg_in_mode_i[23:16] <= {8{IN_REG}};
		cfg_in_ale_sel_i[5:4] <= 2'b11;
		port_i.c <= 8'h81;
		cyc(4);
		rd(OFS_OUT_AB, 8'h69, "out_ab");
		check("ale_reg", imc_o[23:16], 8'h81);
		port_i.c <= 8'h7e;
		cyc(6);
		check("ale_hold", imc_o[23:16], 8'h81);
		cfg_addr_out_i <= 1'b1;
		cyc(3);
		check("addr_out", port_o.b, OFS_OUT_AB);
		host.read({8'h5a, OFS_OUT_AB}, 1'b0, rd_v, rd_ok);
		check("no_drive", rd_ok, 1'b0);
		control_input_2_i <= 1'b1;
		cfg_control_input_2_free_i <= 1'b1;
		cyc(6);
		check("ctl2", array_control_input_2_o, 1'b1);
		foreach (lim[k]) begin
			cfg_pterm_req_i[cel[k]] <= lim[k];
			cyc(4);
			check("fit", expanded_o[cel[k]], 1'b0);
			cfg_pterm_req_i[cel[k]] <= lim[k] + 4'h1;
			cyc(4);
			check("expand", expanded_o[cel[k]], 1'b1);
			check("consume", consumed_o[cel[k] + 1], 1'b1);
			cfg_pterm_req_i[cel[k]] <= '0;
		end
		end_sim();
	end
endmodule : cmh_macrocell_host_tb_top
`default_nettype wire
